// >>> design/recipe_pkg.sv
`default_nettype none
package recipe_pkg;
    localparam int          SLOT_COUNT   = 10;
    localparam int          GROUP_COUNT  = 8;
    localparam int          VALUE_W      = 16;
    localparam int          CHAN_W       = 6;
    localparam int          PARAM_W      = 8;
    localparam logic [3:0]  SLOT_LAST    = 4'h9;
    localparam logic [3:0]  SLOT_FIRST   = 4'h0;
    localparam logic [2:0]  PALETTE_NONE = 3'h0;
    localparam logic [15:0] VALUE_RESET  = 16'h0000;

    // Channel codes: digit value 0-9, letters A..Z as 10..35
    localparam int N_BAD_CHAN = 8;
    localparam logic [N_BAD_CHAN*CHAN_W-1:0] BAD_CHAN = {
        6'h03, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h1d, 6'h21};

    // Excluded channel-parameter pairs
    localparam int N_BAD_PAIR = 9;
    localparam logic [N_BAD_PAIR*(CHAN_W+PARAM_W)-1:0] BAD_PAIR = {
        6'h01, 8'h05, 6'h01, 8'h07, 6'h01, 8'h09,
        6'h01, 8'h08, 6'h09, 8'he3, 6'h10, 8'h01,
        6'h10, 8'h02, 6'h10, 8'h12, 6'h0f, 8'h08};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10
    } load_state_e;
endpackage
`default_nettype wire

// >>> design/recipe_parameter_switcher.sv
// Contract
// - Ten allocation slots name target parameters
// - Target is channel number plus parameter number
// - Eighty values; group zero for no palette
// - Group n follows palette n, slot k
// - Palette change loads selected group into targets
// - Stored value must fit target's range
// - Allocation changes apply only after reset
// - Masked parameters refused as recipe targets
`timescale 1ns/1ps
`default_nettype none
module recipe_parameter_switcher #(
    parameter int VALUE_W = recipe_pkg::VALUE_W
) (
    input  wire logic                              core_clk,
    input  wire logic                              sys_rst,
    input  wire logic                              power_up,
    input  wire logic                              alloc_wr,
    input  wire logic [3:0]                        alloc_slot,
    input  wire logic [recipe_pkg::CHAN_W-1:0]     alloc_channel,
    input  wire logic [recipe_pkg::PARAM_W-1:0]    alloc_param,
    input  wire logic                              alloc_masked,
    input  wire logic                              val_wr,
    input  wire logic [2:0]                        val_group,
    input  wire logic [3:0]                        val_slot,
    input  wire logic signed [VALUE_W-1:0]         val_data,
    input  wire logic signed [VALUE_W-1:0]         val_min,
    input  wire logic signed [VALUE_W-1:0]         val_max,
    input  wire logic [2:0]                        palette_index,
    output logic                                   wr_refused,
    output logic                                   param_wr,
    output logic [recipe_pkg::CHAN_W-1:0]          param_channel,
    output logic [recipe_pkg::PARAM_W-1:0]         param_number,
    output logic [VALUE_W-1:0]                     param_value,
    output logic                                   busy
);
    localparam int CW = recipe_pkg::CHAN_W;
    localparam int PW = recipe_pkg::PARAM_W;
    localparam int NS = recipe_pkg::SLOT_COUNT;
    localparam int NG = recipe_pkg::GROUP_COUNT;

    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        recipe_pkg::load_state_e             state;
        logic [NS-1:0]                       pend_valid;
        logic [NS-1:0][CW-1:0]               pend_chan;
        logic [NS-1:0][PW-1:0]               pend_param;
        logic [NS-1:0]                       act_valid;
        logic [NS-1:0][CW-1:0]               act_chan;
        logic [NS-1:0][PW-1:0]               act_param;
        logic [NG-1:0][NS-1:0][VALUE_W-1:0]  values;
        logic [2:0]                          palette;
        logic [2:0]                          group;
        logic [3:0]                          slot;
        logic                                wr_refused;
        logic                                param_wr;
        logic [CW-1:0]                       param_channel;
        logic [PW-1:0]                       param_number;
        logic [VALUE_W-1:0]                  param_value;
        logic                                busy;
    } switcher_s;

    switcher_s cur;
    switcher_s next_cur;

    // ----------------------------------------
    // Target legality
    // ----------------------------------------
    // Forbidden targets become unused slots, not refusals
    function automatic logic target_allowed(
        input logic [CW-1:0] ch,
        input logic [PW-1:0] pn
    );
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < recipe_pkg::N_BAD_CHAN; i++) begin
            if (ch == recipe_pkg::BAD_CHAN[i*CW +: CW]) begin
                ok = 1'b0;
            end
        end
        for (int i = 0; i < recipe_pkg::N_BAD_PAIR; i++) begin
            if ({ch, pn} == recipe_pkg::BAD_PAIR[i*(CW+PW) +: (CW+PW)]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ----------------------------------------
    // Write screening
    // ----------------------------------------
    logic alloc_bad;
    logic value_bad;

    assign alloc_bad = (alloc_slot > recipe_pkg::SLOT_LAST) || alloc_masked;
    assign value_bad = (val_slot > recipe_pkg::SLOT_LAST) || (val_data < val_min) || (val_data > val_max);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.wr_refused = 1'b0;
        next_cur.param_wr = 1'b0;

        // Allocation lands in the pending copy only
        if (alloc_wr) begin
            if (alloc_bad) begin
                next_cur.wr_refused = 1'b1;
            end else begin
                next_cur.pend_valid[alloc_slot] = target_allowed(alloc_channel, alloc_param);
                next_cur.pend_chan[alloc_slot] = alloc_channel;
                next_cur.pend_param[alloc_slot] = alloc_param;
            end
        end

        // Range is that of the slot's target, given by the host
        if (val_wr) begin
            if (value_bad) begin
                next_cur.wr_refused = 1'b1;
            end else begin
                next_cur.values[val_group][val_slot] = val_data;
            end
        end

        // Change is judged against the palette of the last edge
        next_cur.palette = palette_index;
        case (cur.state)
            recipe_pkg::ST_IDLE: begin
                next_cur.busy = 1'b0;
            end
            recipe_pkg::ST_LOAD: begin
                if (cur.act_valid[cur.slot]) begin
                    next_cur.param_wr = 1'b1;
                    next_cur.param_channel = cur.act_chan[cur.slot];
                    next_cur.param_number = cur.act_param[cur.slot];
                    next_cur.param_value = cur.values[cur.group][cur.slot];
                end
                // Unused slots still spend their cycle, sweep length is fixed
                if (cur.slot == recipe_pkg::SLOT_LAST) begin
                    next_cur.state = recipe_pkg::ST_IDLE;
                    next_cur.busy = 1'b0;
                end else begin
                    next_cur.slot = cur.slot + 4'h1;
                end
            end
            default: begin
                next_cur.state = recipe_pkg::ST_IDLE;
                next_cur.busy = 1'b0;
            end
        endcase

        // A new palette restarts the sweep with its group
        if (palette_index != cur.palette) begin
            next_cur.state = recipe_pkg::ST_LOAD;
            next_cur.group = palette_index;
            next_cur.slot = recipe_pkg::SLOT_FIRST;
            next_cur.busy = 1'b1;
        end

        // Main reset makes pending allocations live, keeps values
        if (sys_rst) begin
            next_cur.act_valid = cur.pend_valid;
            next_cur.act_chan = cur.pend_chan;
            next_cur.act_param = cur.pend_param;
            next_cur.pend_valid = cur.pend_valid;
            next_cur.pend_chan = cur.pend_chan;
            next_cur.pend_param = cur.pend_param;
            next_cur.values = cur.values;
            next_cur.state = recipe_pkg::ST_IDLE;
            next_cur.palette = recipe_pkg::PALETTE_NONE;
            next_cur.group = recipe_pkg::PALETTE_NONE;
            next_cur.slot = recipe_pkg::SLOT_FIRST;
            next_cur.wr_refused = 1'h0;
            next_cur.param_wr = 1'h0;
            next_cur.param_channel = '0;
            next_cur.param_number = '0;
            next_cur.param_value = recipe_pkg::VALUE_RESET;
            next_cur.busy = 1'h0;
        end

        // Power-up clears everything, every slot unused
        if (power_up) begin
            next_cur.state = recipe_pkg::ST_IDLE;
            next_cur.pend_valid = '0;
            next_cur.pend_chan = '0;
            next_cur.pend_param = '0;
            next_cur.act_valid = '0;
            next_cur.act_chan = '0;
            next_cur.act_param = '0;
            next_cur.values = '0;
            next_cur.palette = recipe_pkg::PALETTE_NONE;
            next_cur.group = recipe_pkg::PALETTE_NONE;
            next_cur.slot = recipe_pkg::SLOT_FIRST;
            next_cur.wr_refused = 1'h0;
            next_cur.param_wr = 1'h0;
            next_cur.param_channel = '0;
            next_cur.param_number = '0;
            next_cur.param_value = recipe_pkg::VALUE_RESET;
            next_cur.busy = 1'h0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        cur <= next_cur;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wr_refused = cur.wr_refused;
    assign param_wr = cur.param_wr;
    assign param_channel = cur.param_channel;
    assign param_number = cur.param_number;
    assign param_value = cur.param_value;
    assign busy = cur.busy;
endmodule
`default_nettype wire

// >>> bench/recipe_parameter_switcher_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module recipe_switcher_checker (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       power_up,
    input wire logic       alloc_wr,
    input wire logic [3:0] alloc_slot,
    input wire logic       alloc_masked,
    input wire logic       val_wr,
    input wire logic [2:0] palette_index,
    input wire logic       wr_refused,
    input wire logic       param_wr,
    input wire logic       busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || power_up);
    sequence s_q; $stable(palette_index)[*8] ##1 $stable(palette_index)[*2]; endsequence
    property p_ref_slot; alloc_wr && alloc_slot > 4'h9 |=> wr_refused; endproperty
    property p_ref_mask; alloc_wr && alloc_masked |=> wr_refused; endproperty
    property p_accept; alloc_wr && !alloc_masked && alloc_slot <= 4'h9 && !val_wr |=> !wr_refused; endproperty
    property p_quiet; !alloc_wr && !val_wr |=> !wr_refused; endproperty
    property p_start; palette_index != $past(palette_index) && !$past(sys_rst) && !$past(power_up) |=> busy; endproperty
    property p_len; $rose(busy) ##0 s_q |-> busy ##1 !busy; endproperty
    property p_wr_win; param_wr |-> $past(busy); endproperty
    property p_idle; s_q ##1 $stable(palette_index)[*2] |-> !busy; endproperty
    a_ref_slot: assert property (p_ref_slot) else $error("bad slot not refused");
    a_ref_mask: assert property (p_ref_mask) else $error("masked target not refused");
    a_accept: assert property (p_accept) else $error("good allocation refused");
    a_quiet: assert property (p_quiet) else $error("refusal without write");
    a_start: assert property (p_start) else $error("no sweep on palette change");
    a_len: assert property (p_len) else $error("sweep length wrong");
    a_wr_win: assert property (p_wr_win) else $error("write outside sweep");
    a_idle: assert property (p_idle) else $error("busy without change");
endmodule
bind recipe_parameter_switcher recipe_switcher_checker u_chk (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .power_up      (power_up),
    .alloc_wr      (alloc_wr),
    .alloc_slot    (alloc_slot),
    .alloc_masked  (alloc_masked),
    .val_wr        (val_wr),
    .palette_index (palette_index),
    .wr_refused    (wr_refused),
    .param_wr      (param_wr),
    .busy          (busy)
);
`default_nettype wire

// >>> bench/tb_recipe_parameter_switcher.sv
`timescale 1ns/1ps
`default_nettype none
module tb_recipe_parameter_switcher;
    logic core_clk = 1'b0, sys_rst = 1'b0, power_up = 1'b1, alloc_wr = 1'b0, val_wr = 1'b0, alloc_masked = 1'b0;
    logic wr_refused, param_wr, busy;
    logic [3:0] alloc_slot = 4'h0, val_slot = 4'h0;
    logic [2:0] val_group = 3'h0, palette_index = 3'h0;
    logic [5:0] alloc_channel = 6'h00, param_channel;
    logic [7:0] alloc_param = 8'h00, param_number;
    logic signed [15:0] val_data = 16'h0000, val_min = 16'hfc18, val_max = 16'h03e8, param_value;
    int error_cnt = 0, checks = 0, wcnt = 0;
    recipe_parameter_switcher dut (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .power_up      (power_up),
        .alloc_wr      (alloc_wr),
        .alloc_slot    (alloc_slot),
        .alloc_channel (alloc_channel),
        .alloc_param   (alloc_param),
        .alloc_masked  (alloc_masked),
        .val_wr        (val_wr),
        .val_group     (val_group),
        .val_slot      (val_slot),
        .val_data      (val_data),
        .val_min       (val_min),
        .val_max       (val_max),
        .palette_index (palette_index),
        .wr_refused    (wr_refused),
        .param_wr      (param_wr),
        .param_channel (param_channel),
        .param_number  (param_number),
        .param_value   (param_value),
        .busy          (busy)
    );
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (param_wr === 1'b1) wcnt <= wcnt + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) error_cnt++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic put(input logic k, input logic [3:0] s, input logic [5:0] c, input logic [7:0] p,
                       input logic m, input logic [2:0] g, input logic [15:0] d, input logic r);
        {alloc_wr, val_wr, alloc_slot, val_slot, alloc_channel, alloc_param, alloc_masked, val_group, val_data}
            = {~k, k, s, s, c, p, m, g, d};
        @(posedge core_clk) #5;
        {alloc_wr, val_wr} = 2'b00;
        chk(32'(wr_refused), 32'(r));
        @(posedge core_clk) #5;
    endtask
    task automatic t_sweep(input logic [2:0] pal, input int n, input logic [31:0] e);
        int w0 = wcnt;
        palette_index = pal;
        @(posedge core_clk) #5;
        chk(32'(busy), 32'h1);
        repeat (11) @(posedge core_clk) #5;
        chk(32'(busy), 32'h0);
        chk(32'(wcnt - w0), 32'(n));
        chk({2'b00, param_channel, param_number, param_value}, e);
        $display("sweep to palette %0d done", pal);
    endtask
    task automatic t_refuse();
        put(1'b0, 4'ha, 6'h01, 8'h0a, 1'b0, 3'h0, 16'h0000, 1'b1);
        put(1'b0, 4'h0, 6'h01, 8'h0a, 1'b1, 3'h0, 16'h0000, 1'b1);
        put(1'b1, 4'h0, 6'h00, 8'h00, 1'b0, 3'h1, 16'h07d0, 1'b1);
        $display("refusal test done");
    endtask
    task automatic t_recipe();
        put(1'b0, 4'h0, 6'h01, 8'h0a, 1'b0, 3'h0, 16'h0000, 1'b0);
        put(1'b1, 4'h0, 6'h00, 8'h00, 1'b0, 3'h1, 16'h00c8, 1'b0);
        put(1'b1, 4'h0, 6'h00, 8'h00, 1'b0, 3'h0, 16'h0064, 1'b0);
        t_sweep(3'h1, 0, 32'h0000_0000);
        sys_rst = 1'b1;
        #50 sys_rst = 1'b0;
        t_sweep(3'h1, 1, 32'h010a_00c8);
        t_sweep(3'h0, 1, 32'h010a_0064);
        $display("recipe test done");
    endtask
    task automatic summarize();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000 error_cnt++;
        summarize();
    end
    initial begin
        #80 {power_up, sys_rst} = 2'b01;
        #800 sys_rst = 1'b0;
        t_refuse();
        t_recipe();
        summarize();
    end
endmodule
`default_nettype wire
